// File: logic/rmx_pkg.sv
// Shared constants, register map and pin carriers for the strap pin mux
package rmx_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses, one aligned 32-bit word each)
  // ----------------------------------------------------------------------
  localparam logic [7:0] RMX_OFF_CTRL     = 8'h00;
  localparam logic [7:0] RMX_OFF_FLAG_DIR = 8'h04;
  localparam logic [7:0] RMX_OFF_FLAG_OUT = 8'h08;
  localparam logic [7:0] RMX_OFF_FLAG_IN  = 8'h0C;
  localparam logic [7:0] RMX_OFF_MODE     = 8'h10;
  localparam logic [7:0] RMX_OFF_INT_MASK = 8'h14;
  localparam logic [7:0] RMX_OFF_INT_REQ  = 8'h18;

  // Field positions and reset values
  localparam int         RMX_CTRL_ALT_BIT  = 0;
  localparam int         RMX_CTRL_PDDR_BIT = 1;
  localparam logic [1:0] RMX_CTRL_RST      = 2'h0;
  localparam logic [7:0] RMX_FLAG_RST      = 8'h00;
  localparam logic [5:0] RMX_MASK_RST      = 6'h00;
  localparam int         RMX_STRAP_BIT     = 2;
  localparam int         RMX_FLAGS         = 8;
  localparam int         RMX_SHARED_LO     = 4;
  localparam int         RMX_IRQS          = 6;

  // AXI responses
  localparam logic [1:0] RMX_RESP_OKAY   = 2'h0;
  localparam logic [1:0] RMX_RESP_SLVERR = 2'h2;

  // Pins sampled from outside the clock domain
  typedef struct packed {
    logic [7:0]  flag_lvl;
    logic [23:0] ext_data;
    logic        host_write_enable_n;
    logic        host_read_enable_n;
    logic        host_address_latch;
    logic        host_port_select_n;
    logic [15:0] host_port_addr_data;
    logic        sp_rx_data;
    logic        sp_rx_frame;
    logic        sp_tx_frame;
  } rmx_pin_in_s;

  // Core-side request to the external memory bus
  typedef struct packed {
    logic [13:0] addr;
    logic [23:0] wdata;
    logic [7:0]  byte_hi;
    logic        drive;
    logic        byte_space;
    logic [3:0]  sel;
  } rmx_mem_req_s;

  // True when the byte address falls on a mapped register
  function automatic logic rmx_hit(input logic [7:0] a);
    return a == RMX_OFF_CTRL || a == RMX_OFF_FLAG_DIR ||
           a == RMX_OFF_FLAG_OUT || a == RMX_OFF_FLAG_IN ||
           a == RMX_OFF_MODE || a == RMX_OFF_INT_MASK ||
           a == RMX_OFF_INT_REQ;
  endfunction

endpackage

// File: logic/rmx_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module rmx_sync3 #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // No reset: the strap must be seen while reset is still held
  always_ff @(posedge aclk) begin
    if (ce) begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // A bit changes only once stages two and three agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge aclk) begin
      if (ce && s2_r[i] == s3_r[i]) begin
        q[i] <= s3_r[i];
      end
    end
  end
endmodule

// File: logic/rmx_axil_slave.sv
// AXI4-Lite slave front end for the pin mux registers
`timescale 1ns/100ps
module rmx_axil_slave
  import rmx_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             wr_pulse,
  output logic [7:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  output logic [7:0]       rd_addr,
  input  wire logic [31:0] rd_data
);
  logic aw_full_r;
  logic w_full_r;

  // Ready only when the holding slot is free and the block runs
  assign s_axi_awready = ce && !aw_full_r && !s_axi_bvalid;
  assign s_axi_wready  = ce && !w_full_r && !s_axi_bvalid;
  assign s_axi_arready = ce && !s_axi_rvalid;
  assign wr_pulse      = ce && aw_full_r && w_full_r && !s_axi_bvalid;
  assign rd_addr       = s_axi_araddr;

  // Address and data are captured independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      wr_addr   <= 8'h00;
      wr_data   <= 32'h0000_0000;
      wr_strb   <= 4'h0;
    end else if (ce) begin
      if (wr_pulse) begin
        aw_full_r <= 1'b0;
        w_full_r  <= 1'b0;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_full_r <= 1'b1;
          wr_addr   <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_full_r <= 1'b1;
          wr_data  <= s_axi_wdata;
          wr_strb  <= s_axi_wstrb;
        end
      end
    end
  end

  // Write response one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RMX_RESP_OKAY;
    end else if (ce) begin
      if (wr_pulse) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= rmx_hit(wr_addr) ? RMX_RESP_OKAY : RMX_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read data captured on the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RMX_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_data;
        s_axi_rresp  <= rmx_hit(s_axi_araddr) ? RMX_RESP_OKAY
                                               : RMX_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// File: logic/rmx_pin_mux.sv
// Reset-time memory mode strap and pin multiplexer, top level
// Function
// - Strap level during reset fixes memory mode
// - Strap low gives full memory, byte DMA
// - Full mode drives 14-bit address, 24-bit data
// - Byte accesses put address on upper data
// - Strap high gives 16-bit host port
// - Host mode: one address bit, upper data
// - Host drives strobes; device returns acknowledge
// - Mode pins sampled in reset, flags afterward
// - Unmasked shared pin raises interrupt either way
// - Software switches second serial port pin roles
// - Pull-resistor strap: flag input in power-down
// - Buffered strap: flag output in power-down
// - Bus roles fixed; serial roles change anytime
// - Serial clock stays usable in alternate mode
`timescale 1ns/100ps
module rmx_pin_mux
  import rmx_pkg::*;
(
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               ce,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire rmx_pin_in_s        pins,
  output logic [7:0]              flag_pin_drv,
  output logic [7:0]              flag_pin_en,
  input  wire rmx_mem_req_s       core_req,
  output logic [23:0]             core_rdata,
  output logic [13:0]             external_address_bus,
  output logic [23:0]             ext_data_drv,
  output logic [23:0]             ext_data_en,
  output logic                    combined_memory_select_n,
  output logic                    program_memory_select_n,
  output logic                    data_memory_select_n,
  output logic                    io_memory_select_n,
  output logic                    byte_dma_path_en,
  output logic                    host_internal_dma_en,
  output logic [15:0]             host_port_addr_data_drv,
  output logic                    host_port_addr_data_en,
  output logic                    host_port_acknowledge_n,
  output logic [15:0]             host_ram_addr,
  output logic [15:0]             host_ram_wdata,
  output logic                    host_ram_we,
  input  wire logic [15:0]        host_ram_rdata,
  input  wire logic               power_down,
  input  wire logic               sp_sclk_int,
  input  wire logic               sp_tx_data_int,
  input  wire logic               sp_tx_frame_int,
  input  wire logic               sp_rx_frame_int,
  output logic                    sp_sclk,
  output logic                    sp_tx_data,
  output logic                    sp_tx_frame,
  output logic                    sp_rx_frame_drv,
  output logic                    sp_rx_data_int,
  output logic                    sp_rx_frame_lvl,
  output logic                    sp_tx_frame_lvl,
  output logic [RMX_IRQS-1:0]     irq_req
);
  // ----------------------------------------------------------------------
  // Pin sampling and register front end
  // ----------------------------------------------------------------------
  rmx_pin_in_s p;
  logic        wr_pulse;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;

  rmx_sync3 #(.W($bits(rmx_pin_in_s))) u_sync (
    .aclk (aclk),
    .ce   (ce),
    .d    (pins),
    .q    (p)
  );

  rmx_axil_slave u_bus (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .ce            (ce),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_pulse      (wr_pulse),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data)
  );

  // ----------------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------------
  logic [2:0] mode_r;
  logic       run_r;
  logic       host_mode;

  // Tracks the pins while reset is held; last value wins at release
  always_ff @(posedge aclk) begin
    if (ce && !aresetn) begin
      mode_r <= p.flag_lvl[2:0];
    end
  end

  // Flag roles start only once reset is gone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_r <= 1'b0;
    end else if (ce) begin
      run_r <= 1'b1;
    end
  end

  assign host_mode            = mode_r[RMX_STRAP_BIT];
  assign byte_dma_path_en     = !host_mode;
  assign host_internal_dma_en = host_mode;

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  logic [1:0]          ctrl_r;
  logic [7:0]          flag_dir_r;
  logic [7:0]          flag_out_r;
  logic [RMX_IRQS-1:0] mask_r;

  // Mode word is read-only: bus roles cannot move after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r     <= RMX_CTRL_RST;
      flag_dir_r <= RMX_FLAG_RST;
      flag_out_r <= RMX_FLAG_RST;
      mask_r     <= RMX_MASK_RST;
    end else if (ce && wr_pulse && wr_strb[0]) begin
      case (wr_addr)
        RMX_OFF_CTRL:     ctrl_r     <= wr_data[1:0];
        RMX_OFF_FLAG_DIR: flag_dir_r <= wr_data[7:0];
        RMX_OFF_FLAG_OUT: flag_out_r <= wr_data[7:0];
        RMX_OFF_INT_MASK: mask_r     <= wr_data[RMX_IRQS-1:0];
        default: ;
      endcase
    end
  end

  // Read mux; unused upper bits read as zero
  always_comb begin
    rd_data = 32'h0000_0000;
    case (rd_addr)
      RMX_OFF_CTRL:     rd_data[1:0]          = ctrl_r;
      RMX_OFF_FLAG_DIR: rd_data[7:0]          = flag_dir_r;
      RMX_OFF_FLAG_OUT: rd_data[7:0]          = flag_out_r;
      RMX_OFF_FLAG_IN:  rd_data[7:0]          = p.flag_lvl;
      RMX_OFF_MODE:     rd_data[2:0]          = mode_r;
      RMX_OFF_INT_MASK: rd_data[RMX_IRQS-1:0] = mask_r;
      RMX_OFF_INT_REQ:  rd_data[RMX_IRQS-1:0] = irq_req;
      default:          rd_data               = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------------
  // Flag pins and shared interrupts
  // ----------------------------------------------------------------------
  logic alt_sel;
  assign alt_sel = ctrl_r[RMX_CTRL_ALT_BIT];

  // In power-down the strap flag follows the board policy bit, so a
  // pulled pin stops switching and a buffered pin never floats
  always_comb begin
    flag_pin_en = run_r ? flag_dir_r : 8'h00;
    if (run_r && power_down) begin
      flag_pin_en[RMX_STRAP_BIT] = ctrl_r[RMX_CTRL_PDDR_BIT];
    end
  end
  assign flag_pin_drv = flag_out_r;

  // Level read back from the pin, so an own flag drive also vectors
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_req <= '0;
    end else if (ce) begin
      irq_req[3:0] <= ~p.flag_lvl[7:RMX_SHARED_LO] & mask_r[3:0];
      irq_req[4]   <= alt_sel && !p.sp_rx_frame && mask_r[4];
      irq_req[5]   <= alt_sel && !p.sp_tx_frame && mask_r[5];
    end
  end

  // ----------------------------------------------------------------------
  // Second serial port role switch
  // ----------------------------------------------------------------------
  // Serial clock and both frame levels pass in both roles; data and frame drives swap with the bit
  assign sp_sclk         = sp_sclk_int;
  assign sp_tx_data      = alt_sel ? flag_out_r[0] : sp_tx_data_int;
  assign sp_tx_frame     = alt_sel ? 1'b1 : sp_tx_frame_int;
  assign sp_rx_frame_drv = alt_sel ? 1'b1 : sp_rx_frame_int;
  assign sp_rx_data_int  = alt_sel ? 1'b0 : p.sp_rx_data;
  assign sp_rx_frame_lvl = p.sp_rx_frame;
  assign sp_tx_frame_lvl = p.sp_tx_frame;

  // ----------------------------------------------------------------------
  // External memory bus
  // ----------------------------------------------------------------------
  // Host mode trades the address bus for the host port; peripherals
  // then need an outside latch on the one address bit and the selects
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      external_address_bus <= 14'h0000;
      ext_data_drv         <= 24'h00_0000;
      ext_data_en          <= 24'h00_0000;
      {combined_memory_select_n, program_memory_select_n,
       data_memory_select_n, io_memory_select_n} <= 4'hF;
    end else if (ce) begin
      {combined_memory_select_n, program_memory_select_n,
       data_memory_select_n, io_memory_select_n} <= ~core_req.sel;
      if (host_mode) begin
        external_address_bus <= {13'h0000, core_req.addr[0]};
        ext_data_drv <= {core_req.wdata[15:0], 8'h00};
        ext_data_en  <= {{16{core_req.drive}}, 8'h00};
      end else begin
        external_address_bus <= core_req.addr;
        ext_data_en  <= {24{core_req.drive}};
        if (core_req.byte_space) begin
          ext_data_drv <= {core_req.byte_hi, core_req.wdata[15:0]};
          ext_data_en  <= {8'hFF, {16{core_req.drive}}};
        end else begin
          ext_data_drv <= core_req.wdata;
        end
      end
    end
  end

  // Read data from the pins, narrowed to the upper lines in host mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_rdata <= 24'h00_0000;
    end else if (ce) begin
      core_rdata <= host_mode ? {8'h00, p.ext_data[23:8]} : p.ext_data;
    end
  end

  // ----------------------------------------------------------------------
  // Host port
  // ----------------------------------------------------------------------
  logic wr_act;
  logic rd_act;
  logic wr_prev_r;
  logic rd_prev_r;

  assign wr_act = host_mode && !p.host_port_select_n &&
                  !p.host_write_enable_n;
  assign rd_act = host_mode && !p.host_port_select_n &&
                  !p.host_read_enable_n;

  // Address latch, write commit on strobe release, auto increment
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_ram_addr  <= 16'h0000;
      host_ram_wdata <= 16'h0000;
      host_ram_we    <= 1'b0;
      wr_prev_r      <= 1'b0;
      rd_prev_r      <= 1'b0;
    end else if (ce) begin
      wr_prev_r   <= wr_act;
      rd_prev_r   <= rd_act;
      host_ram_we <= wr_prev_r && !wr_act;
      if (host_mode && !p.host_port_select_n && p.host_address_latch) begin
        host_ram_addr <= p.host_port_addr_data;
      end else if ((wr_prev_r && !wr_act) || (rd_prev_r && !rd_act)) begin
        host_ram_addr <= host_ram_addr + 16'h0001;
      end
      if (wr_act) begin
        host_ram_wdata <= p.host_port_addr_data;
      end
    end
  end

  // Read drive and acknowledge back to the host
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_port_addr_data_drv <= 16'h0000;
      host_port_addr_data_en  <= 1'b0;
      host_port_acknowledge_n <= 1'b1;
    end else if (ce) begin
      host_port_addr_data_drv <= host_ram_rdata;
      host_port_addr_data_en  <= rd_act;
      host_port_acknowledge_n <= !(wr_act || rd_act);
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_mode_held: assert property (
    $past(aresetn) |-> $stable(mode_r))
    else $error("mode changed while running");
  chk_strap_take: assert property (
    $rose(aresetn) |-> mode_r == $past(p.flag_lvl[2:0]))
    else $error("strap not captured at release");
  chk_flags_off: assert property (
    $rose(aresetn) |-> flag_pin_en == 8'h00)
    else $error("flag driven during reset");
  chk_mode_paths: assert property (
    byte_dma_path_en == !host_mode && host_internal_dma_en == host_mode)
    else $error("dma path enable wrong");
  chk_full_addr: assert property (
    ce && !host_mode |=> external_address_bus == $past(core_req.addr))
    else $error("full mode address wrong");
  chk_byte_hi: assert property (
    ce && !host_mode && core_req.byte_space
    |=> ext_data_drv[23:16] == $past(core_req.byte_hi))
    else $error("byte address not on upper data");
  chk_host_narrow: assert property (
    $past(ce) && host_mode |-> external_address_bus[13:1] == 13'h0000
    && ext_data_en[7:0] == 8'h00)
    else $error("host mode bus too wide");
  chk_host_ack: assert property (
    ce && host_mode && !p.host_port_select_n && !p.host_read_enable_n
    |=> !host_port_acknowledge_n && host_port_addr_data_en)
    else $error("host read not acknowledged");
  chk_irq_share: assert property (
    ce |=> irq_req[3:0] == $past(~p.flag_lvl[7:4] & mask_r[3:0]))
    else $error("shared interrupt mismatch");
  chk_alt_swap: assert property (
    alt_sel |-> sp_tx_data == flag_out_r[0] && sp_sclk == sp_sclk_int)
    else $error("serial alternate roles wrong");
endmodule

// File: testbench/rmx_board_model.sv
// Board model: strap buffer, pull resistors and interrupt sources
`timescale 1ns/100ps
module rmx_board_model (
  input  wire logic       aresetn,
  input  wire logic       strap,
  input  wire logic [7:0] pull,
  input  wire logic [7:0] ext_low,
  input  wire logic [7:0] drv,
  input  wire logic [7:0] en,
  output logic      [7:0] lvl
);
  // Pin level; the strap buffer is enabled by reset only, then falls to pull
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      lvl[i] = pull[i];
      if (en[i])
        lvl[i] = drv[i];
      if (i == 2 && !aresetn)
        lvl[i] = strap;
      if (ext_low[i])
        lvl[i] = 1'b0;
    end
  end
endmodule

// File: testbench/rmx_pin_mux_tb.sv
// Self-checking bench for the strap pin mux
`timescale 1ns/100ps
module rmx_pin_mux_tb;
  import rmx_pkg::*;
  logic aclk, aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, power_down, sp_sclk_int, strap;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, sp_sclk, sp_tx_data, sp_tx_frame;
  logic combined_memory_select_n, byte_dma_path_en, host_internal_dma_en;
  logic [7:0] s_axi_awaddr, s_axi_araddr, flag_pin_drv, flag_pin_en;
  logic [7:0] pull, ext_low, lvl;
  logic [3:0] hctl;
  logic rxf, hack_n;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [13:0] external_address_bus;
  logic [23:0] ext_data_drv, ext_data_en;
  logic [5:0] irq_req;
  rmx_mem_req_s core_req;
  rmx_pin_in_s pins;
  int miscompares, n_compared;
  // Host strobes and receive frame are driven; flag pins come from board
  assign pins = {lvl, 24'h00_0000, hctl, 16'h0000, 1'b1, rxf, 1'b1};
  rmx_board_model u_board (.aresetn, .strap, .pull, .ext_low,
    .drv(flag_pin_drv), .en(flag_pin_en), .lvl);
  rmx_pin_mux u_dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pins, .flag_pin_drv,
    .flag_pin_en, .core_req, .core_rdata(), .external_address_bus,
    .ext_data_drv, .ext_data_en, .combined_memory_select_n,
    .program_memory_select_n(), .data_memory_select_n(),
    .io_memory_select_n(), .byte_dma_path_en, .host_internal_dma_en,
    .host_port_addr_data_drv(), .host_port_addr_data_en(),
    .host_port_acknowledge_n(hack_n), .host_ram_addr(), .host_ram_wdata(),
    .host_ram_we(), .host_ram_rdata(16'h0000), .power_down, .sp_sclk_int,
    .sp_tx_data_int(1'b0), .sp_tx_frame_int(1'b0), .sp_rx_frame_int(1'b0),
    .sp_sclk, .sp_tx_data, .sp_tx_frame, .sp_rx_frame_drv(),
    .sp_rx_data_int(), .sp_rx_frame_lvl(), .sp_tx_frame_lvl(), .irq_req);
  // Clock, 10 ns period
  initial begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Readies are sampled mid-cycle; they only move after a rising edge
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw, ta, tw, tb;
    pa = 1;
    pw = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (pa || pw) begin
      @(negedge aclk);
      ta = pa && s_axi_awready;
      tw = pw && s_axi_wready;
      @(posedge aclk);
      if (ta) begin
        pa = 0;
        s_axi_awvalid <= 0;
      end
      if (tw) begin
        pw = 0;
        s_axi_wvalid <= 0;
      end
    end
    do begin
      @(negedge aclk);
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
    end while (!tb);
  endtask
  task rd(input logic [7:0] a);
    logic ta;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(negedge aclk);
      ta = s_axi_arready;
      @(posedge aclk);
    end while (!ta);
    s_axi_arvalid <= 0;
    do begin
      @(negedge aclk);
      ta = s_axi_rvalid;
      q = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
    end while (!ta);
  endtask
  task rst(input logic s);
    strap <= s;
    aresetn <= 0;
    cyc(16);
    aresetn <= 1;
    cyc(8);
  endtask
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    cyc(20000);
    miscompares++;
    report_and_stop;
  end
  // Main sequence; after each reset the strap pin's pull is the opposite
  initial begin
    {ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h8;
    {s_axi_arvalid, s_axi_rready, power_down} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {sp_sclk_int, ext_low, pull} = {1'b1, 8'h00, 8'hff};
    {hctl, rxf} = 5'h1b;
    core_req = '0;
    rst(0);
    rd(RMX_OFF_MODE); chk(q, 32'h0000_0003);
    chk(byte_dma_path_en, 1);
    rd(RMX_OFF_CTRL); chk(q, 0);
    rd(RMX_OFF_FLAG_DIR); chk(q, 0);
    rd(RMX_OFF_FLAG_OUT); chk(q, 0);
    rd(RMX_OFF_INT_MASK); chk(q, 0);
    rd(8'h1c); chk(r, RMX_RESP_SLVERR);
    $display("test 1 done");
    core_req <= '{14'h2a5d, 24'h12_3456, 8'hc3, 1'b1, 1'b1, 4'h8};
    cyc(2);
    chk(external_address_bus, 14'h2a5d);
    chk(combined_memory_select_n, 0);
    chk(ext_data_drv, 24'hc3_3456);
    chk(ext_data_en[23:16], 8'hff);
    $display("test 2 done");
    wr(RMX_OFF_FLAG_DIR, 8'h14); chk(r, RMX_RESP_OKAY);
    wr(RMX_OFF_FLAG_OUT, 8'h04);
    cyc(1); chk(flag_pin_en, 8'h14);
    wr(RMX_OFF_INT_MASK, 1);
    cyc(8); chk(irq_req, 1);
    wr(RMX_OFF_FLAG_OUT, 0);
    wr(RMX_OFF_FLAG_DIR, 8'h04);
    ext_low <= 8'h10;
    cyc(8); rd(RMX_OFF_INT_REQ); chk(q, 1);
    ext_low <= 0;
    wr(RMX_OFF_INT_MASK, 0);
    cyc(2); chk(irq_req, 0);
    rd(RMX_OFF_MODE); chk(q, 32'h0000_0003);
    $display("test 3 done");
    power_down <= 1;
    wr(RMX_OFF_CTRL, 0);
    cyc(2); chk(flag_pin_en[2], 0);
    wr(RMX_OFF_CTRL, 2);
    cyc(2); chk(flag_pin_en[2], 1);
    power_down <= 0;
    wr(RMX_OFF_FLAG_OUT, 1);
    wr(RMX_OFF_CTRL, 1);
    cyc(1); chk({sp_tx_data, sp_tx_frame, sp_sclk}, 3'h7);
    sp_sclk_int <= 0;
    wr(RMX_OFF_INT_MASK, 8'h10);
    rxf <= 0;
    cyc(8); chk({irq_req, sp_sclk}, 7'h20);
    rxf <= 1;
    wr(RMX_OFF_CTRL, 0);
    cyc(1); chk({sp_tx_data, sp_tx_frame, sp_sclk}, 3'h0);
    $display("test 4 done");
    pull <= 8'hfb;
    rst(1);
    rd(RMX_OFF_MODE); chk(q, 32'h0000_0007);
    chk(host_internal_dma_en, 1);
    chk(external_address_bus, 14'h0001);
    chk(ext_data_drv, 24'h34_5600);
    hctl <= 4'h8;
    cyc(8); chk(hack_n, 0);
    hctl <= 4'hd;
    cyc(8); chk(hack_n, 1);
    chk(ext_data_en[7:0], 8'h00);
    $display("test 5 done");
    report_and_stop;
  end
endmodule
